// ---- design/askey_fifo.sv ----
/*
  Synchronous FIFO with valid/ready handshake on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
module askey_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // Storage words
  logic [AW-1:0] wr_r;             // Write pointer
  logic [AW-1:0] rd_r;             // Read pointer
  logic [AW:0] cnt_r;              // Fill level
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write; no reset needed as data is qualified by count
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Never overrun or underrun
  fill_bound_a: assert property (@(posedge clk) disable iff (rst)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule

// ---- design/askey_keyer.sv ----
/*
  Automatic sequence keyer: plays stored character rows while a sequence
  key is held and hands each character, mapped for the selected mode, to
  the encoder through an 8-word FIFO.
  Assumes synchronous key inputs, a matrix presented as a flat bit vector
  (one 7-bit row per character) and an encoder that takes one word per
  valid/ready handshake and raises enc_done when it has sent it.
*/
// How it works
// R1: Three keys each replay stored sequence automatically
// R2: Call and auxiliary keys hold three characters
// R3: Identifier key replays up to fifteen characters
// R4: Held key repeats sequence from first character
// R5: Rows: call 1-3, aux 4-6, ident next 15
// R6: Row holds ASCII bits A_0..A_6, diode is one
// R7: Morse: CR go-ahead, LF end, unknown eight dots
// R8: Identifier ends at terminating row, used plus one
// R9: Ascending rows; next char after encoder finishes
`timescale 1ns/10ps
module askey_keyer
  import askey_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic general_call_key,       // Held high while pressed
  input wire logic aux_key,
  input wire logic identifier_key,
  input wire logic morse_mode,             // 1 Morse, 0 teleprinter
  input wire logic [ROWS*CHAR_W-1:0] matrix, // Row k at bits k*7 +: 7
  input wire logic [4:0] term_hole,        // Jumper hole 1..16
  output logic [FIFO_W-1:0] enc_data,      // {substitute flag, code}
  output logic enc_valid,
  input wire logic enc_ready,
  input wire logic enc_done,               // Pulse: character sent
  output logic busy_r                      // Sequence in progress
);
  askey_state_t state_r;
  askey_sel_t sel_r;                // Key being played
  logic [4:0] row_r;                // Current matrix row
  logic [4:0] term_r;               // Captured terminating hole
  logic [FIFO_W-1:0] push_data_r;   // Word offered to the FIFO
  logic push_valid_r;
  logic fifo_in_ready;
  logic [FIFO_W-1:0] fifo_data;
  logic fifo_valid;
  logic enc_valid_r;
  logic [FIFO_W-1:0] enc_data_r;
  logic any_key;
  logic [4:0] last_row;
  logic [4:0] first_row;

  // Row fetch: diode present reads one, so no inversion needed
  function automatic logic [6:0] row_code(input logic [4:0] r);
    row_code = matrix[r*CHAR_W +: CHAR_W]; // see R6
  endfunction

  // Morse substitution; letters, digits and listed punctuation pass
  function automatic logic [7:0] map_char(input logic [6:0] c,
                                          input logic morse);
    logic [6:0] u;
    u = (c >= 7'h61 && c <= 7'h7a) ? c - 7'h20 : c;
    if (!morse) begin
      map_char = {1'b0, c};
    end else if (c == ASCII_CR) begin
      map_char = {1'b1, MORSE_GO_AHEAD}; // see R7
    end else if (c == ASCII_LF) begin
      map_char = {1'b1, MORSE_END_MSG}; // see R7
    end else if ((u >= 7'h41 && u <= 7'h5a) || (u >= 7'h27 && u <= 7'h3b)
                 || u == 7'h20 || u == 7'h3f || u == 7'h22) begin
      map_char = {1'b0, u};
    end else begin
      map_char = {1'b1, MORSE_ERROR}; // see R7
    end
  endfunction

  assign any_key = general_call_key | aux_key | identifier_key;

  // Bounds of the selected key's rows
  always_comb begin
    case (sel_r)
      ASKEY_CALL: begin
        first_row = CALL_FIRST; // see R5
        last_row = CALL_LAST; // see R2
      end
      ASKEY_AUX: begin
        first_row = AUX_FIRST; // see R5
        last_row = AUX_LAST; // see R2
      end
      default: begin
        first_row = IDENT_FIRST;
        // Hole n marks n-1 used rows; hole 1 would mean an empty message
        last_row = IDENT_FIRST + term_r - 5'h02; // see R8 R3
      end
    endcase
  end

  // Terminating hole is a wiring strap, caught only while idle so the
  // end row cannot move under a running row counter and be skipped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      term_r <= TERM_RESET;
    end else if (state_r == ASKEY_IDLE && term_hole >= 5'h02
                 && term_hole <= TERM_RESET) begin
      term_r <= term_hole; // see R8
    end
  end

  // Sequencer: one character per cycle of load then wait for done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ASKEY_IDLE;
      sel_r <= ASKEY_CALL;
      row_r <= CALL_FIRST;
      push_valid_r <= 1'b0;
      push_data_r <= '0;
      busy_r <= 1'b0;
    end else begin
      case (state_r)
        ASKEY_IDLE: begin
          // Priority call, aux, ident if several keys are down together
          if (any_key) begin // see R1
            busy_r <= 1'b1;
            state_r <= ASKEY_LOAD;
            if (general_call_key) begin
              sel_r <= ASKEY_CALL;
              row_r <= CALL_FIRST;
            end else if (aux_key) begin
              sel_r <= ASKEY_AUX;
              row_r <= AUX_FIRST;
            end else begin
              sel_r <= ASKEY_IDENT;
              row_r <= IDENT_FIRST;
            end
          end
        end
        ASKEY_LOAD: begin
          // Hold the word until the FIFO accepts it (back-pressure)
          if (!push_valid_r) begin
            push_data_r <= map_char(row_code(row_r), morse_mode);
            push_valid_r <= 1'b1;
          end else if (fifo_in_ready) begin
            push_valid_r <= 1'b0;
            state_r <= ASKEY_WAIT;
          end
        end
        ASKEY_WAIT: begin
          // Next character only after the encoder reports done
          if (enc_done) begin // see R9
            if (row_r != last_row) begin
              row_r <= row_r + 5'h01; // see R9
              state_r <= ASKEY_LOAD;
            end else if (any_key) begin
              row_r <= first_row; // see R4
              state_r <= ASKEY_LOAD;
            end else begin
              // Released keys still finish the sequence in progress
              state_r <= ASKEY_IDLE;
              busy_r <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= ASKEY_IDLE;
        end
      endcase
    end
  end

  askey_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(push_data_r),
    .in_valid(push_valid_r),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(!enc_valid_r || enc_ready)
  );

  // Output register so encoder-facing signals come from flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enc_valid_r <= 1'b0;
      enc_data_r <= '0;
    end else if (!enc_valid_r || enc_ready) begin
      enc_valid_r <= fifo_valid;
      // Keep the last word when empty; unwritten FIFO words are unknown
      if (fifo_valid) begin
        enc_data_r <= fifo_data;
      end
    end
  end
  assign enc_valid = enc_valid_r;
  assign enc_data = enc_data_r;

  // Row stays within the selected key's block
  row_range_a: assert property (@(posedge clk) disable iff (rst) // see R5
    state_r != ASKEY_IDLE |-> row_r >= first_row && row_r <= last_row)
    else $error("row outside key block");
  // Rows advance by one on done
  row_step_a: assert property (@(posedge clk) disable iff (rst) // see R9
    state_r == ASKEY_WAIT && enc_done && row_r != last_row
    |=> row_r == $past(row_r) + 5'h01) else $error("row skipped");
  // Held key wraps to first row
  seq_repeat_a: assert property (@(posedge clk) disable iff (rst) // see R4
    state_r == ASKEY_WAIT && enc_done && row_r == last_row && any_key
    |=> row_r == first_row && state_r == ASKEY_LOAD)
    else $error("no repeat");
  // No new load before done
  wait_done_a: assert property (@(posedge clk) disable iff (rst) // see R9
    state_r == ASKEY_WAIT && !enc_done |=> state_r == ASKEY_WAIT)
    else $error("left wait early");
  // Key press starts a sequence
  key_start_a: assert property (@(posedge clk) disable iff (rst) // see R1
    state_r == ASKEY_IDLE && any_key |=> state_r == ASKEY_LOAD ##1
    push_valid_r) else $error("key ignored");
  // CR in Morse becomes go-ahead
  cr_map_a: assert property (@(posedge clk) disable iff (rst) // see R7
    state_r == ASKEY_LOAD && !push_valid_r && morse_mode
    && row_code(row_r) == ASCII_CR
    |=> push_data_r == {1'b1, MORSE_GO_AHEAD}) else $error("CR map");
  // Short keys never exceed three rows
  short_len_a: assert property (@(posedge clk) disable iff (rst) // see R2
    sel_r != ASKEY_IDENT |-> last_row - first_row == 5'h02)
    else $error("short length");
  // Identifier length bounded by fifteen rows
  ident_len_a: assert property (@(posedge clk) disable iff (rst) // see R3 R8
    sel_r == ASKEY_IDENT |-> last_row < IDENT_FIRST + 5'd15)
    else $error("ident too long");
endmodule

// ---- design/askey_pkg.sv ----
/*
  Constants for the automatic sequence keyer: matrix layout, row counts,
  character codes and Morse mapping codes.
  Assumes nothing of its surroundings; imported by askey_keyer and the bench.
*/
package askey_pkg;
  localparam int CHAR_W = 7;               // ASCII bits A_0..A_6
  localparam int ROWS = 21;                // 3 call + 3 aux + 15 ident
  localparam int ROW_W = 5;                // Row index width
  localparam logic [4:0] CALL_FIRST = 5'h00; // Rows one to three
  localparam logic [4:0] CALL_LAST = 5'h02;
  localparam logic [4:0] AUX_FIRST = 5'h03;  // Rows four to six
  localparam logic [4:0] AUX_LAST = 5'h05;
  localparam logic [4:0] IDENT_FIRST = 5'h06; // Next fifteen rows
  localparam int IDENT_MAX = 15;
  localparam logic [4:0] TERM_RESET = 5'h10; // Hole 16: all fifteen used
  localparam int FIFO_W = 8;               // Flag + 7-bit code
  localparam int FIFO_D = 8;
  localparam logic [6:0] ASCII_CR = 7'h0d;
  localparam logic [6:0] ASCII_LF = 7'h0a;
  // Morse-side substitutes carried in the output word (flag bit set)
  localparam logic [6:0] MORSE_GO_AHEAD = 7'h01; // go_ahead_prosign
  localparam logic [6:0] MORSE_END_MSG = 7'h02;  // end_of_message_prosign
  localparam logic [6:0] MORSE_ERROR = 7'h03;    // Eight dots
  typedef enum logic [1:0] {ASKEY_CALL, ASKEY_AUX, ASKEY_IDENT} askey_sel_t;
  typedef enum {ASKEY_IDLE, ASKEY_LOAD, ASKEY_WAIT} askey_state_t;
endpackage

// ---- tb/askey_enc_model.sv ----
/*
  Encoder stand-in: takes one word per handshake, pulses enc_done later.
  Assumes the keyer drives enc_data/enc_valid; outputs change 1 ns late.
*/
`timescale 1ns/10ps
module askey_enc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] enc_data,
  input wire logic enc_valid,
  output logic enc_ready,
  output logic enc_done
);
  int d; // Send time of the current word
  // Ready wanders so the keyer sees stalls; done comes 0..6 cycles late
  initial begin
    enc_ready = 1'b0;
    enc_done = 1'b0;
    forever begin
      @(posedge clk);
      if (!rst && enc_valid === 1'b1 && enc_ready === 1'b1) begin
        d = $urandom_range(0, 6);
        #1 enc_ready = 1'b0;
        repeat (d) @(posedge clk);
        #1 enc_done = 1'b1;
        @(posedge clk);
        #1 enc_done = 1'b0;
      end else begin
        #1 enc_ready = ($urandom_range(0, 3) != 0);
      end
    end
  end
endmodule

// ---- tb/askey_keyer_tb.sv ----
/*
  Bench for the keyer: random rows, every key, both modes, held keys.
  Assumes askey_enc_model on the encoder side.
*/
`timescale 1ns/10ps
module askey_keyer_tb
  import askey_pkg::*;
();
  logic clk;
  logic rst = 1'b1;
  logic [2:0] keys = 3'h0; // Call, aux, ident
  logic mode = 1'b0;
  logic [ROWS*CHAR_W-1:0] mat = '0;
  logic [4:0] term = 5'h10;
  logic [7:0] enc_data;
  logic enc_valid, enc_ready, enc_done, busy;
  logic [7:0] rx_q[$]; // Words seen crossing to the encoder
  logic [6:0] corner[8] = '{7'h0d, 7'h0a, 7'h61, 7'h7f, 7'h20, 7'h3f,
                            7'h27, 7'h3b};
  int bad_count = 0;
  int n_checks = 0;

  askey_keyer u_askey_keyer (.clk(clk), .rst(rst),
    .general_call_key(keys[0]), .aux_key(keys[1]),
    .identifier_key(keys[2]), .morse_mode(mode), .matrix(mat),
    .term_hole(term), .enc_data(enc_data), .enc_valid(enc_valid),
    .enc_ready(enc_ready), .enc_done(enc_done), .busy_r(busy));
  askey_enc_model u_askey_enc_model (.clk(clk), .rst(rst),
    .enc_data(enc_data), .enc_valid(enc_valid),
    .enc_ready(enc_ready), .enc_done(enc_done));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Record each accepted word at its handshake edge
  always @(posedge clk) begin
    if (!rst && enc_valid === 1'b1 && enc_ready === 1'b1) begin
      rx_q.push_back(enc_data);
    end
  end

  // Expected word: raw in teleprinter mode, mapped in Morse mode
  function automatic logic [7:0] exp_word(logic [6:0] c, logic m);
    if (!m) return {1'b0, c};
    if (c == ASCII_CR) return {1'b1, MORSE_GO_AHEAD};
    if (c == ASCII_LF) return {1'b1, MORSE_END_MSG};
    if (c >= 7'h61 && c <= 7'h7a) return {1'b0, c - 7'h20};
    if ((c >= 7'h41 && c <= 7'h5a) || c == 7'h20 || c == 7'h22 ||
        (c >= 7'h27 && c <= 7'h3b) || c == 7'h3f) return {1'b0, c};
    return {1'b1, MORSE_ERROR};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One held-key run: fill rows, hold past a wrap, release, compare
  task automatic run_test(input int t);
    int key, base, len, n;
    logic [6:0] c; // Stored code of the row under comparison
    key = t % 3;
    mode = ((t / 3) % 2 == 1);
    @(posedge clk);
    #1;
    for (int r = 0; r < ROWS; r++) begin
      mat[r*CHAR_W +: CHAR_W] = $urandom_range(0, 1) ?
        corner[$urandom_range(0, 7)] : 7'($urandom);
    end
    term = (t == 2) ? 5'h02 : (t == 5) ? 5'h10 : 5'($urandom_range(2, 16));
    base = (key == 0) ? 0 : (key == 1) ? 3 : 6;
    len = (key == 2) ? term - 1 : 3;
    rx_q.delete();
    @(posedge clk);
    #1 keys[key] = 1'b1;
    n = 0;
    while (rx_q.size() < len + 1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(8'(n >= 3000), 8'h00);
    #1 keys = 3'h0;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(8'(n >= 3000), 8'h00);
    repeat (3) @(posedge clk);
    check(8'(rx_q.size() % len), 8'h00);
    check({7'h0, rx_q.size() > len}, 8'h01);
    foreach (rx_q[i]) begin
      c = mat[(base + i % len)*CHAR_W +: CHAR_W];
      check(rx_q[i], exp_word(c, mode));
    end
    $display("Test %0d done: key %0d mode %0b len %0d words %0d",
      t, key, mode, len, rx_q.size());
  endtask

  // Main sequence
  initial begin
    int s;
    s = $urandom(32'h0000_b364);
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
    check({7'h0, busy}, 8'h00);
    check({7'h0, enc_valid}, 8'h00);
    for (int t = 0; t < 12; t++) begin
      run_test(t);
    end
    report_and_stop();
  end

  // Watchdog: tests need well under 50k cycles
  initial begin
    #250000;
    bad_count++;
    $display("ERROR t=%0t watchdog seen=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule
